// [profiler_pkg.sv]
// constants shared by the profiling event config loader
// assumes a 32-bit word interface to the control block memory
package profiler_pkg;
  localparam int WORD_W = 32;
  localparam int VAL_W = 26;
  localparam int VAL_MSB = 25;
  localparam int MAX_EVENTS = 6;
  localparam int EVT_IDX_W = 3;
  localparam logic [VAL_W-1:0] MIN_INTERVAL_DEF = 26'h000FFFF;
  localparam int FLAG_SAMPLE = 1;
  localparam int FLAG_EVT_LO = 2;
  localparam int FLAG_CONTINUOUS_MODE_SELECT = 29;
  localparam int FLAG_TSC = 30;
  localparam int FLAG_INT = 31;
  localparam logic [WORD_W-1:0] FLAG_AVAIL_DEF = 32'hE000007E;
  localparam logic [2:0] SAMPLE_EVT = 3'h1;
  localparam logic [WORD_W-1:0] ZERO_WORD = 32'h00000000;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FLAGS = 3'b001,
    ST_INT = 3'b011,
    ST_CNT = 3'b010,
    ST_STORE = 3'b110
  } ld_state_t;
endpackage

// [profiling_event_config_loader.sv]
// profiling event config loader: control block load/store, counters, ring head logic
// assumes a single-cycle word memory port and event pulses on the core clock
//
// How it works
// - sample event records after interval+1 sample ops, randomization added
// - negative sample interval loads as zero and zero is written back
// - only the sample event may sit below the minimum interval
// - retired-insn event records after interval+1 retirements, randomization added
// - retired-insn interval below minimum or negative becomes minimum, written back
// - counters load signed, negative as zero; store writes live count
// - values are 26-bit signed in low bits; top reserved bits zero
// - events 3 to max index handled like retired-insn pair
// - load reads flags word selecting events and threshold interrupts
// - flags written back with unavailable feature bits cleared
// - flags bit 1 enables sample op after sanitization
// - flags bits 2..6 enable the five hardware events in order
// - continuous mode keeps storing and advancing head on overflow
// - otherwise synchronized mode
// - timestamp field holds counter when selected and available, else zero
// - flags bit 31 enables threshold interrupts after sanitization
// - after head advance, used space compared against threshold raises interrupt
// - synchronized mode full buffer keeps head, counts missed events
//
// The plain strobed port and the address map are this design's own decisions.
module profiling_event_config_loader
  import profiler_pkg::*;
#(
  parameter int NUM_EVT = MAX_EVENTS,
  parameter logic [VAL_W-1:0] MIN_INTERVAL = MIN_INTERVAL_DEF,
  parameter logic [WORD_W-1:0] FLAG_AVAIL = FLAG_AVAIL_DEF,
  parameter int BUF_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // operations
  input wire logic loadOp,
  input wire logic storeOp,
  // control block memory port
  output logic [7:0] memAddr,
  output logic memRd,
  output logic memWr,
  output logic [WORD_W-1:0] memWdata,
  input wire logic [WORD_W-1:0] memRdata,
  // events, index 1 is the sample op
  input wire logic [NUM_EVT:1] eventPulse,
  input wire logic [VAL_W-1:0] randomAdj,
  input wire logic [63:0] timestampIn,
  // ring buffer state
  input wire logic [BUF_W-1:0] ringTail,
  input wire logic [BUF_W-1:0] ringSize,
  input wire logic [BUF_W-1:0] ringThreshold,
  input wire logic [BUF_W-1:0] recordSize,
  // outputs
  output logic busy,
  output logic recordValid,
  output logic [EVT_IDX_W-1:0] recordEvent,
  output logic [63:0] recordStamp,
  output logic [BUF_W-1:0] ringHead,
  output logic [31:0] missedCount,
  output logic thresholdIrq,
  output logic [WORD_W-1:0] activeFlags
);
  localparam logic [7:0] FLAGS_OFS = 8'h00;
  localparam logic [7:0] EVT_BASE = 8'h02;

  ld_state_t state_ff, nxt_state;
  logic [EVT_IDX_W-1:0] idx_ff, nxt_idx;
  logic [WORD_W-1:0] flags_ff, nxt_flags;
  logic [VAL_W-1:0] intv_ff [1:NUM_EVT];
  logic [VAL_W-1:0] nxt_intv [1:NUM_EVT];
  logic [VAL_W-1:0] cnt_ff [1:NUM_EVT];
  logic [VAL_W-1:0] nxt_cnt [1:NUM_EVT];
  logic [7:0] addr_ff, nxt_addr;
  logic rd_ff, nxt_rd, wr_ff, nxt_wr, pend_ff, nxt_pend;
  logic [WORD_W-1:0] wdata_ff, nxt_wdata;
  logic recV_ff, nxt_recV;
  logic [EVT_IDX_W-1:0] recE_ff, nxt_recE;
  logic [63:0] stamp_ff, nxt_stamp;
  logic [BUF_W-1:0] head_ff, nxt_head;
  logic [31:0] miss_ff, nxt_miss;
  logic irq_ff, nxt_irq;
  logic [NUM_EVT:1] fire;
  logic [VAL_W-1:0] rdVal, sanVal;
  logic [BUF_W:0] headInc;
  logic [BUF_W-1:0] headNext, used;

  assign rdVal = memRdata[VAL_MSB:0];

  // per-event counters: decrement, reload with randomization on underflow
  for (genvar g = 1; g <= NUM_EVT; g++) begin : g_evt
    logic en;
    assign en = flags_ff[g] && (state_ff == ST_IDLE);
    assign fire[g] = en && eventPulse[g] && (cnt_ff[g] == '0);
  end

  // load value sanitization per event kind
  always_comb begin
    sanVal = rdVal;
    if (state_ff == ST_INT) begin
      if (idx_ff == SAMPLE_EVT) begin
        if (rdVal[VAL_MSB]) sanVal = '0;
      end else if (rdVal[VAL_MSB] || (rdVal < MIN_INTERVAL)) begin
        sanVal = MIN_INTERVAL;
      end
    end else if (rdVal[VAL_MSB]) begin
      sanVal = '0;
    end
  end

  // ring head next position with wrap
  always_comb begin
    headInc = {1'b0, head_ff} + {1'b0, recordSize};
    headNext = (headInc >= {1'b0, ringSize}) ?
      headInc[BUF_W-1:0] - ringSize : headInc[BUF_W-1:0];
    used = (headNext >= ringTail) ? headNext - ringTail : headNext + ringSize - ringTail;
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    nxt_flags = flags_ff;
    nxt_intv = intv_ff;
    nxt_cnt = cnt_ff;
    nxt_addr = addr_ff;
    nxt_rd = 1'b0;
    nxt_wr = 1'b0;
    nxt_pend = 1'b0;
    nxt_wdata = wdata_ff;
    nxt_recV = 1'b0;
    nxt_recE = recE_ff;
    nxt_stamp = stamp_ff;
    nxt_head = head_ff;
    nxt_miss = miss_ff;
    nxt_irq = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        for (int i = 1; i <= NUM_EVT; i++) begin
          if (flags_ff[i] && eventPulse[i] && !fire[i]) begin
            nxt_cnt[i] = cnt_ff[i] - 26'h0000001;
          end
          if (fire[i]) begin
            nxt_cnt[i] = intv_ff[i] + randomAdj;
          end
        end
        for (int i = NUM_EVT; i >= 1; i--) begin
          if (fire[i]) begin
            nxt_recV = 1'b1;
            nxt_recE = EVT_IDX_W'(i);
          end
        end
        if (fire != '0) begin
          nxt_stamp = flags_ff[FLAG_TSC] ? timestampIn : 64'h0000000000000000;
          if (!flags_ff[FLAG_CONTINUOUS_MODE_SELECT] && (headNext == ringTail)) begin
            nxt_miss = miss_ff + 32'h00000001;
          end else begin
            nxt_head = headNext;
            nxt_irq = flags_ff[FLAG_INT] && (used >= ringThreshold);
          end
        end
        if (loadOp) begin
          nxt_state = ST_FLAGS;
          nxt_addr = FLAGS_OFS;
          nxt_rd = 1'b1;
          nxt_pend = 1'b1;
          nxt_flags = '0;
        end else if (storeOp) begin
          nxt_state = ST_STORE;
          nxt_idx = SAMPLE_EVT;
        end
      end
      // write-back and next read never share a cycle: the port has one address
      ST_FLAGS: begin
        if (!pend_ff) begin
          nxt_flags = memRdata & FLAG_AVAIL;
          nxt_wdata = memRdata & FLAG_AVAIL;
          nxt_wr = 1'b1;
          nxt_idx = SAMPLE_EVT;
          nxt_state = ST_INT;
        end
      end
      ST_INT: begin
        if (wr_ff) begin
          nxt_addr = EVT_BASE;
          nxt_rd = 1'b1;
          nxt_pend = 1'b1;
        end else if (!pend_ff) begin
          nxt_intv[idx_ff] = sanVal;
          nxt_wdata = {6'h00, sanVal};
          nxt_wr = 1'b1;
          nxt_state = ST_CNT;
        end
      end
      ST_CNT: begin
        if (wr_ff) begin
          nxt_addr = addr_ff + 8'h01;
          nxt_rd = 1'b1;
          nxt_pend = 1'b1;
        end else if (!pend_ff) begin
          nxt_cnt[idx_ff] = sanVal;
          if (idx_ff == EVT_IDX_W'(NUM_EVT)) begin
            nxt_state = ST_IDLE;
          end else begin
            nxt_idx = idx_ff + 3'h1;
            nxt_state = ST_INT;
            nxt_addr = addr_ff + 8'h01;
            nxt_rd = 1'b1;
            nxt_pend = 1'b1;
          end
        end
      end
      ST_STORE: begin
        nxt_addr = EVT_BASE + {4'h0, idx_ff, 1'b1} - 8'h02;
        nxt_wdata = {6'h00, cnt_ff[idx_ff]};
        nxt_wr = 1'b1;
        if (idx_ff == EVT_IDX_W'(NUM_EVT)) nxt_state = ST_IDLE;
        else nxt_idx = idx_ff + 3'h1;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      idx_ff <= '0;
      flags_ff <= '0;
      for (int i = 1; i <= NUM_EVT; i++) begin
        intv_ff[i] <= '0;
        cnt_ff[i] <= '0;
      end
      addr_ff <= '0;
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
      pend_ff <= 1'b0;
      wdata_ff <= '0;
      recV_ff <= 1'b0;
      recE_ff <= '0;
      stamp_ff <= '0;
      head_ff <= '0;
      miss_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      flags_ff <= nxt_flags;
      intv_ff <= nxt_intv;
      cnt_ff <= nxt_cnt;
      addr_ff <= nxt_addr;
      rd_ff <= nxt_rd;
      wr_ff <= nxt_wr;
      pend_ff <= nxt_pend;
      wdata_ff <= nxt_wdata;
      recV_ff <= nxt_recV;
      recE_ff <= nxt_recE;
      stamp_ff <= nxt_stamp;
      head_ff <= nxt_head;
      miss_ff <= nxt_miss;
      irq_ff <= nxt_irq;
    end
  end

  // a write-back goes to the word just read, so one address register serves both
  assign memAddr = addr_ff;
  assign memRd = rd_ff;
  assign memWr = wr_ff;
  assign memWdata = wdata_ff;
  assign busy = (state_ff != ST_IDLE);
  assign recordValid = recV_ff;
  assign recordEvent = recE_ff;
  assign recordStamp = stamp_ff;
  assign ringHead = head_ff;
  assign missedCount = miss_ff;
  assign thresholdIrq = irq_ff;
  assign activeFlags = flags_ff;
endmodule

// [loader_sva.sv]
// checker for the profiling event config loader ports
// assumes binding onto the loader with its own parameters
module loader_sva
  import profiler_pkg::*;
#(parameter int NUM_EVT = MAX_EVENTS, parameter logic [VAL_W-1:0] MIN_INTERVAL = MIN_INTERVAL_DEF,
  parameter logic [WORD_W-1:0] FLAG_AVAIL = FLAG_AVAIL_DEF, parameter int BUF_W = 16) (
  // watched ports
  input wire logic clk, rst, loadOp, storeOp, memRd, memWr, busy, recordValid, thresholdIrq,
  input wire logic [7:0] memAddr,
  input wire logic [WORD_W-1:0] memWdata, memRdata, activeFlags,
  input wire logic [NUM_EVT:1] eventPulse,
  input wire logic [VAL_W-1:0] randomAdj,
  input wire logic [63:0] timestampIn, recordStamp,
  input wire logic [BUF_W-1:0] ringTail, ringSize, ringThreshold, recordSize, ringHead,
  input wire logic [EVT_IDX_W-1:0] recordEvent,
  input wire logic [31:0] missedCount
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  flag_clear_a: assert property (memWr && memAddr == 8'h00 |-> (memWdata & ~FLAG_AVAIL) == 0)
    else $error("flags written with unavailable bits");
  active_avail_a: assert property ((activeFlags & ~FLAG_AVAIL) == 0)
    else $error("active flags hold unavailable bits");
  irq_enable_a: assert property (thresholdIrq |-> activeFlags[FLAG_INT])
    else $error("interrupt while disabled");
  rec_enable_a: assert property (recordValid |-> activeFlags[recordEvent])
    else $error("record from disabled event");
  wr_upper_a: assert property (memWr && memAddr != 8'h00 |-> memWdata[31:26] == 6'h00)
    else $error("upper bits written nonzero");
  sample_int_a: assert property (memWr && memAddr == 8'h02 |-> !memWdata[VAL_MSB])
    else $error("negative sample interval written");
  min_int_a: assert property (memWr && !memAddr[0] && memAddr >= 8'h04 && !busy == 0
    |-> memWdata[VAL_W-1:0] >= MIN_INTERVAL)
    else $error("interval below minimum written");
  stamp_zero_a: assert property (recordValid && !activeFlags[FLAG_TSC] |-> recordStamp == 0)
    else $error("stamp not zero");
  load_busy_a: assert property (loadOp && !busy |=> busy && memRd && memAddr == 8'h00)
    else $error("load did not read flags");
  rec_c: cover property (recordValid);
  irq_c: cover property (thresholdIrq);
  store_c: cover property (storeOp && !busy);
endmodule

bind profiling_event_config_loader loader_sva #(.NUM_EVT(NUM_EVT), .MIN_INTERVAL(MIN_INTERVAL),
  .FLAG_AVAIL(FLAG_AVAIL), .BUF_W(BUF_W)) chk (.*);

// [testbench.sv]
// self-checking bench for the profiling event config loader
// assumes the bench models the control block memory itself
module testbench;
  import profiler_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, loadOp = 0, storeOp = 0;
  logic [7:0] memAddr;
  logic memRd, memWr, busy, recordValid, thresholdIrq;
  logic [31:0] memWdata, memRdata = 0, activeFlags, missedCount, mem [0:7];
  logic [2:1] eventPulse = 0;
  logic [63:0] recordStamp, timestampIn = 64'h0123456789ABCDEF;
  logic [15:0] ringHead;
  logic [2:0] recordEvent, lastEvt;
  logic [25:0] randomAdj = 26'h0000000;
  logic [15:0] ringTail = 16'h0000;
  int n_errors = 0, samples_checked = 0, nRec = 0, nIrq = 0;
  // short minimum keeps reload counts small
  profiling_event_config_loader #(.NUM_EVT(2), .MIN_INTERVAL(26'h0000010)) dut (.clk(clk),
    .rst(rst), .loadOp(loadOp), .storeOp(storeOp), .memAddr(memAddr), .memRd(memRd),
    .memWr(memWr), .memWdata(memWdata), .memRdata(memRdata), .eventPulse(eventPulse),
    .randomAdj(randomAdj), .timestampIn(timestampIn), .ringTail(ringTail),
    .ringSize(16'h0100), .ringThreshold(16'h0000), .recordSize(16'h0020), .busy(busy),
    .recordValid(recordValid), .recordEvent(recordEvent), .recordStamp(recordStamp),
    .ringHead(ringHead), .missedCount(missedCount), .thresholdIrq(thresholdIrq),
    .activeFlags(activeFlags));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (memRd) memRdata <= mem[memAddr[2:0]];
    if (memWr) mem[memAddr[2:0]] <= memWdata;
    if (recordValid === 1'b1) begin
      nRec <= nRec + 1;
      lastEvt <= recordEvent;
      if (recordStamp !== (activeFlags[FLAG_TSC] ? timestampIn : 64'h0)) nRec <= 99;
    end
    if (thresholdIrq === 1'b1) nIrq <= nIrq + 1;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic op(input logic isLoad);
    @(posedge clk) if (isLoad) loadOp <= 1; else storeOp <= 1;
    @(posedge clk) begin loadOp <= 0; storeOp <= 0; end
    // look off the edge so busy and the memory model have settled
    #1;
    for (int i = 0; i < 100 && busy !== 1'b0; i++) begin
      @(posedge clk);
      #1;
      if (i == 99) n_errors++;
    end
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic load(input logic [31:0] f, i1, c1, i2, c2);
    mem[0] = f; mem[2] = i1; mem[3] = c1; mem[4] = i2; mem[5] = c2;
    op(1);
  endtask
  task automatic sanitize_test;
    load(32'hFFFFFFFF, 32'hFFFFFFFF, 32'h00000005, 32'h00000003, 32'h03FFFFF0);
    chk(mem[0], 32'hFFFFFFFF & FLAG_AVAIL_DEF);
    chk(activeFlags, 32'hFFFFFFFF & FLAG_AVAIL_DEF);
    chk(mem[2], 32'h0);
    chk(mem[4], 32'h10);
    op(0);
    chk(mem[3], 32'h5);
    chk(mem[5], 32'h0);
    $display("sanitize_test done");
  endtask
  task automatic pulse(input int k, input int expRec, input logic [2:0] evt);
    int r0;
    r0 = nRec;
    @(posedge clk) eventPulse <= 2'(1 << (k - 1));
    @(posedge clk) eventPulse <= 0;
    repeat (4) @(posedge clk);
    chk(nRec - r0, expRec);
    if (expRec == 1) chk(lastEvt, evt);
  endtask
  task automatic count_test(input logic [31:0] f, input int expIrq, input logic [15:0] expHead);
    int q0;
    q0 = nIrq;
    load(f, 32'h0, 32'h0, 32'h10, 32'h2);
    pulse(1, 1, 3'h1);
    pulse(1, 1, 3'h1);
    pulse(2, 0, 3'h2);
    pulse(2, 0, 3'h2);
    pulse(2, 1, 3'h2);
    chk(nIrq - q0, expIrq);
    chk(ringHead, expHead);
    chk(missedCount, 32'h0);
    $display("count_test done");
  endtask
  task automatic stop_test;
    $display("checks=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    sanitize_test();
    count_test(32'hC0000006, 3, 16'h0060);
    count_test(32'h00000006, 0, 16'h00C0);
    stop_test();
  end
  initial begin
    #20000;
    n_errors++;
    stop_test();
  end
endmodule
